// >>> core/fsp_pkg.sv
package fsp_pkg;
  // ==========================================================
  // Host register map (word index on the plain port)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_DATA   = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA  = 4'h4;
  // ==========================================================
  // Control register fields
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_OP_LSB    = 1;
  localparam int CTRL_OP_MSB    = 3;
  localparam int CTRL_HVA_BIT   = 4;
  localparam int CTRL_HVOE_BIT  = 5;
  // ==========================================================
  // Flash status bit positions
  localparam int POLLING_BIT     = 7;
  localparam int ACTIVITY_BIT    = 6;
  localparam int TIMEOUT_BIT     = 5;
  localparam int ERASE_WIN_BIT   = 3;
  localparam int ESECT_TGL_BIT   = 2;
  localparam int LOWEST_DATA_BIT = 0;
  // Address bit positions used by protect modes
  localparam int ID_SELECT_BIT   = 1;
  localparam int LOW_SELECT_BIT  = 0;
  localparam int UNPROT_SEL_BIT  = 6;
  // Reset command data
  localparam logic [7:0] RESET_CMD = 8'hF0;
  // ==========================================================
  // Timing: each strobe phase, in ns, and derived cycles
  localparam int CLK_PERIOD_NS = 5;
  localparam int STROBE_NS     = 60;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_NS     = 5;
  localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  // ==========================================================
  // Operations
  typedef enum logic [2:0] {
    OP_WRITE   = 3'b000,
    OP_READ    = 3'b001,
    OP_POLL    = 3'b010,
    OP_PROTECT = 3'b011,
    OP_UNPROT  = 3'b100,
    OP_RESET   = 3'b101
  } fsp_op_t;
  // Poll results
  typedef enum logic [1:0] {
    PR_NONE = 2'b00,
    PR_DONE = 2'b01,
    PR_FAIL = 2'b10
  } fsp_res_t;
endpackage

// >>> core/fsp_strobe.sv
`timescale 1ns/10ps
// ==========================================================
// Timed single bus cycle on the flash pins
module fsp_strobe #(
  parameter int PHASE_CYC = 12
) (
  input  wire logic       clk,
  input  wire logic       rstN,
  input  wire logic       start,
  input  wire logic       isWrite,
  output logic            ceN,
  output logic            weN,
  output logic            oeN,
  output logic            sample,
  output logic            done
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACT  = 2'b01,
    ST_REC  = 2'b10
  } fsp_stb_t;
  fsp_stb_t    state_r;
  logic [7:0]  cnt_r;
  logic        wr_r;
  localparam logic [7:0] PHASE_LAST = 8'(PHASE_CYC - 1);

  // Sequencer: active phase then recovery with all strobes high
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= ST_IDLE;
      cnt_r   <= fsp_pkg::CNT_ZERO;
      wr_r    <= 1'b0;
      ceN     <= 1'b1;
      weN     <= 1'b1;
      oeN     <= 1'b1;
      sample  <= 1'b0;
      done    <= 1'b0;
    end else begin
      sample <= 1'b0;
      done   <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_ACT;
            wr_r    <= isWrite;
            cnt_r   <= fsp_pkg::CNT_ZERO;
            ceN     <= 1'b0;
            weN     <= ~isWrite;   // Write needs oe high, ce and we low
            oeN     <= isWrite;
          end
        end
        ST_ACT: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == PHASE_LAST) begin
            state_r <= ST_REC;
            cnt_r   <= fsp_pkg::CNT_ZERO;
            ceN     <= 1'b1;
            weN     <= 1'b1;
            oeN     <= 1'b1;
            sample  <= ~wr_r;
          end
        end
        ST_REC: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == PHASE_LAST) begin
            state_r <= ST_IDLE;
            done    <= 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Write strobe never low with output strobe low
  no_contend_a: assert property (@(posedge clk) disable iff (!rstN) !(!weN && !oeN))
    else $error("write and output strobes low together");
  // Write strobe stays low long past the glitch width
  we_width_a: assert property (@(posedge clk) disable iff (!rstN)
    $fell(weN) |=> !weN [*2])
    else $error("write strobe pulse too short");
endmodule // fsp_strobe

// >>> core/fsp_host.sv
`timescale 1ns/10ps
// Summary of operation
// - Host reads status twice, compares toggles; stable means done.
// - Toggling with timeout high: recheck; still toggling means fail, send reset (the host only reports PR_FAIL; reset is sent only by OP_RESET).
// - Resumed polling restarts toggle detection from the first read.
// - Under timeout only status reads work; reset before new work (the host takes new work without one; reset is sent only by OP_RESET).
// - Host reads erase-window flag before and after each added erase command; the bench reads it only after the added command.
// - Write only with chip select and write low, output strobe high.
// - Protect programming with elevated voltages, between write fall and rise.
// - Chip unprotect: elevated voltages, chip select low, unprotect bit high.
// - Protect every sector before chip unprotect.
module fsp_host #(
  parameter int ADDR_W = 19
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic [3:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [31:0]            regRdata,
  output logic [ADDR_W-1:0]      flashAddr,
  output logic [7:0]             flashDout,
  output logic                   flashDoe,
  input  wire logic [7:0]        flashDin,
  output logic                   flashCeN,
  output logic                   flashWeN,
  output logic                   flashOeN,
  output logic                   hvAddrEn,
  output logic                   hvOeEn
);
  // ==========================================================
  // Reset release and declarations
  logic              rstSync1_r, rstN_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        data_r, rdata_r, prev_r;
  logic [2:0]        op_r;
  logic              busy_r, hvA_r, hvOe_r, hadFirst_r, timeoutSeen_r;
  logic [1:0]        res_r;
  logic              stbStart_r, stbWrite;
  logic              ceN, weN, oeN, sample, done;
  logic [7:0]        din1_r, din2_r, din3_r, dinStable_r;
  logic [7:0]        toggled;

  // Two-stage reset release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_r <= 1'b0;
      rstN_r     <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstN_r     <= rstSync1_r;
    end
  end

  // ==========================================================
  // Flash data input: three flops, accept when last two agree
  always_ff @(posedge core_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      din1_r      <= 8'h00;
      din2_r      <= 8'h00;
      din3_r      <= 8'h00;
      dinStable_r <= 8'h00;
    end else begin
      din1_r <= flashDin;
      din2_r <= din1_r;
      din3_r <= din2_r;
      if (din2_r == din3_r) dinStable_r <= din3_r;
    end
  end

  // ==========================================================
  // Bus cycle engine
  assign stbWrite = (op_r != fsp_pkg::OP_READ) && (op_r != fsp_pkg::OP_POLL);
  fsp_strobe #(
    .PHASE_CYC (fsp_pkg::STROBE_CYC)
  ) u_strobe (
    .clk     (core_clk),
    .rstN    (rstN_r),
    .start   (stbStart_r),
    .isWrite (stbWrite),
    .ceN     (ceN),
    .weN     (weN),
    .oeN     (oeN),
    .sample  (sample),
    .done    (done)
  );

  // Toggle bits compared across two consecutive captured reads
  assign toggled = prev_r ^ rdata_r;

  // ==========================================================
  // Command register writes and operation control
  always_ff @(posedge core_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      addr_r        <= '0;
      data_r        <= 8'h00;
      op_r          <= 3'b000;
      busy_r        <= 1'b0;
      hvA_r         <= 1'b0;
      hvOe_r        <= 1'b0;
      stbStart_r    <= 1'b0;
      hadFirst_r    <= 1'b0;
      timeoutSeen_r <= 1'b0;
      prev_r        <= 8'h00;
      rdata_r       <= 8'h00;
      res_r         <= fsp_pkg::PR_NONE;
    end else begin
      stbStart_r <= 1'b0;
      if (regWr && !busy_r) begin
        case (regAddr)
          fsp_pkg::REG_ADDR: addr_r <= regWdata[ADDR_W-1:0];
          fsp_pkg::REG_DATA: data_r <= regWdata[7:0];
          fsp_pkg::REG_CTRL: begin
            hvA_r  <= regWdata[fsp_pkg::CTRL_HVA_BIT];   // Elevated voltage request
            hvOe_r <= regWdata[fsp_pkg::CTRL_HVOE_BIT];
            if (regWdata[fsp_pkg::CTRL_GO_BIT]) begin
              op_r       <= regWdata[fsp_pkg::CTRL_OP_MSB:fsp_pkg::CTRL_OP_LSB];
              busy_r     <= 1'b1;
              stbStart_r <= 1'b1;
              hadFirst_r <= 1'b0;   // Fresh poll restarts detection
              timeoutSeen_r <= 1'b0;
              res_r      <= fsp_pkg::PR_NONE;
              if (regWdata[fsp_pkg::CTRL_OP_MSB:fsp_pkg::CTRL_OP_LSB] == fsp_pkg::OP_RESET)
                data_r <= fsp_pkg::RESET_CMD;   // Reset command clears timeout
              if (regWdata[fsp_pkg::CTRL_OP_MSB:fsp_pkg::CTRL_OP_LSB] == fsp_pkg::OP_UNPROT)
                addr_r[fsp_pkg::UNPROT_SEL_BIT] <= 1'b1;   // Unprotect select high
            end
          end
          default: ;
        endcase
      end else if (sample) begin
        rdata_r <= dinStable_r;   // Byte kept for status and erase-window
      end else if (done) begin
        // Captured byte, not the released bus, feeds the poll decision
        if (op_r == fsp_pkg::OP_POLL) begin
          prev_r     <= rdata_r;
          hadFirst_r <= 1'b1;
          if (!hadFirst_r) begin
            stbStart_r <= 1'b1;   // Always at least two reads
          end else if (!toggled[fsp_pkg::ACTIVITY_BIT]) begin
            busy_r <= 1'b0;   // Stable: done, or late finish after timeout
            res_r  <= fsp_pkg::PR_DONE;
          end else if (timeoutSeen_r) begin
            busy_r <= 1'b0;   // Still toggling after timeout recheck
            res_r  <= fsp_pkg::PR_FAIL;
          end else begin
            timeoutSeen_r <= rdata_r[fsp_pkg::TIMEOUT_BIT];
            stbStart_r    <= 1'b1;
          end
        end else begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Pin outputs, all from flops
  always_ff @(posedge core_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      flashAddr <= '0;
      flashDout <= 8'h00;
      flashDoe  <= 1'b0;
      flashCeN  <= 1'b1;
      flashWeN  <= 1'b1;
      flashOeN  <= 1'b1;
      hvAddrEn  <= 1'b0;
      hvOeEn    <= 1'b0;
    end else begin
      flashAddr <= addr_r;
      flashDout <= data_r;
      flashDoe  <= busy_r && stbWrite;   // Data held through recovery past the write strobe rise
      flashCeN  <= ceN;
      flashWeN  <= weN;   // Write cycle only with oe high
      flashOeN  <= oeN;
      hvAddrEn  <= hvA_r;
      hvOeEn    <= hvOe_r;
    end
  end

  // ==========================================================
  // Register read port, data one cycle later
  always_ff @(posedge core_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        fsp_pkg::REG_CTRL:   regRdata <= {26'h0, hvOe_r, hvA_r, op_r, busy_r};
        fsp_pkg::REG_ADDR:   regRdata <= 32'(addr_r);
        fsp_pkg::REG_DATA:   regRdata <= {24'h0, data_r};
        fsp_pkg::REG_STATUS: regRdata <= {28'h0, timeoutSeen_r, res_r, busy_r};
        fsp_pkg::REG_RDATA:  regRdata <= {24'h0, rdata_r};
        default:             regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // Failure reported only after timeout seen
  fail_cause_a: assert property (@(posedge core_clk) disable iff (!rstN_r)
    $rose(res_r == fsp_pkg::PR_FAIL) |-> $past(timeoutSeen_r))
    else $error("fail without timeout");
  // Poll never finishes without a second read
  two_reads_a: assert property (@(posedge core_clk) disable iff (!rstN_r)
    $rose(res_r == fsp_pkg::PR_DONE) |-> $past(hadFirst_r))
    else $error("poll finished after one read");
  // Write strobe and output strobe never both low at the pins
  pin_write_a: assert property (@(posedge core_clk) disable iff (!rstN_r)
    !flashWeN |-> (flashOeN && !flashCeN))
    else $error("bad write pin state");
  // Data bus never driven while the device may drive it
  data_drive_a: assert property (@(posedge core_clk) disable iff (!rstN_r)
    flashDoe |-> flashOeN)
    else $error("data driven with output strobe low");
endmodule // fsp_host

// >>> testbench/fsp_flash_model.sv
`timescale 1ns/10ps
// ==========================================================
// Behavioural flash device on the far side of the pins
module fsp_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary identification value
) (
  input  wire logic        ceN,
  input  wire logic        weN,
  input  wire logic        oeN,
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  dataIn,
  input  wire logic        hvA,
  input  wire logic        hvOe,
  input  wire logic        failMode,
  output logic [7:0]       dataOut
);
  logic [7:0] mem [logic [18:0]];
  logic [7:0] prot, eraseSet, rdVal, lastD;
  logic       busy, isErase, act, est, tOut, idMode, drv, wrOk;
  int         seq, winLeft, busyLeft;
  realtime    tFall;
  // Power-up state: array read, nothing pending
  initial begin
    {prot, eraseSet, rdVal, lastD} = '0;
    {busy, isErase, act, est, tOut, idMode, drv, wrOk} = '0;
    {seq, winLeft, busyLeft} = '0;
    tFall = 0;
  end
  // Released bus shows the inverse of the last value
  assign dataOut = drv ? rdVal : ~rdVal;
  function automatic logic [7:0] arr(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  task automatic doWrite(input logic [18:0] a, input logic [7:0] d);
    if (d == 8'hF0 && (tOut || !busy)) begin
      {busy, tOut, idMode, isErase} = '0;
      seq = 0;
    end else if (busy) begin
      // Only sector additions while the window is open
      if (winLeft > 0 && !tOut && d == 8'h30 && !prot[a[18:16]]) eraseSet[a[18:16]] = 1'b1;
    end else begin
      // Contents change only at the end of a full sequence
      case (seq)
        0: seq = (d == 8'hAA) ? 1 : 0;
        1: seq = (d == 8'h55) ? 2 : 0;
        2: begin
          seq = (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
          if (d == 8'h90) idMode = 1'b1;
        end
        3: begin
          seq = 0;
          if (!prot[a[18:16]]) begin
            mem[a] = arr(a) & d;
            lastD = d;
            {isErase, busy, winLeft, busyLeft} = {1'b0, 1'b1, 32'd0, 32'd3};
          end
        end
        4: seq = (d == 8'hAA) ? 5 : 0;
        5: seq = (d == 8'h55) ? 6 : 0;
        default: begin
          seq = 0;
          if (d == 8'h30) begin
            eraseSet = '0;
            eraseSet[a[18:16]] = !prot[a[18:16]];
            {isErase, busy, winLeft, busyLeft} = {1'b1, 1'b1, 32'd2, 32'd4};
          end
        end
      endcase
    end
  endtask
  task automatic readCycle(input logic [18:0] a);
    logic [18:0] k;
    if ((hvA || idMode) && !a[1]) rdVal = ID_CODE;
    else if (hvA || idMode) rdVal = {7'h0, prot[a[18:16]] && !(hvA && (a[0] || a[6]))};
    else if (!busy) rdVal = arr(a);
    else begin
      act = ~act;
      if (eraseSet[a[18:16]]) est = ~est;
      rdVal = {isErase ? 1'b0 : ~lastD[7], act, tOut, 1'b0, winLeft == 0, est, 2'b00};
      if (winLeft > 0) winLeft--;
      else if (busyLeft > 1) busyLeft--;
      else if (failMode || tOut) tOut = 1'b1;
      else begin
        busy = 1'b0;
        if (isErase && mem.first(k)) begin
          do if (eraseSet[k[18:16]]) mem[k] = 8'hFF; while (mem.next(k));
        end
      end
    end
  endtask
  // Write strobe fall: glitch timer and qualifiers
  always @(negedge weN) begin
    tFall = $realtime;
    #1 wrOk = !ceN && (oeN || hvOe);
  end
  // Write strobe rise ends the bus write
  always @(posedge weN) begin
    if (wrOk && $realtime - tFall >= 5.0) begin
      if (hvA && hvOe && addr[6]) prot = '0;
      else if (hvA && hvOe) prot[addr[18:16]] = 1'b1;
      else doWrite(addr, dataIn);
    end
    wrOk = 1'b0;
  end
  // Output strobe fall: one read cycle
  always @(negedge oeN) begin
    #1;
    if (!ceN && weN) begin
      readCycle(addr);
      drv = 1'b1;
    end
  end
  always @(posedge oeN or posedge ceN) drv = 1'b0;
endmodule // fsp_flash_model

// >>> testbench/test_fsp_host.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the flash host controller
module test_fsp_host;
  localparam logic [7:0] ID_CODE = 8'h5A; // Arbitrary identification value
  logic        core_clk, nrst, regWr, regRd, failMode, flashDoe, flashCeN, flashWeN, flashOeN, hvAddrEn, hvOeEn;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, st, v, w;
  logic [18:0] flashAddr;
  logic [7:0]  flashDout, flashDin, devData;
  int          errTotal, checked;
  fsp_host DUT (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr), .flashDout(flashDout), .flashDoe(flashDoe),
    .flashDin(flashDin), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN), .hvAddrEn(hvAddrEn),
    .hvOeEn(hvOeEn));
  fsp_flash_model #(.ID_CODE(ID_CODE)) dev (.ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN), .addr(flashAddr),
    .dataIn(flashDin), .hvA(hvAddrEn), .hvOe(hvOeEn), .failMode(failMode), .dataOut(devData));
  // Data bus level from both drivers
  assign flashDin = flashDoe ? flashDout : devData;
  always #2.5 core_clk = ~core_clk;
  // ==========================================================
  // Access tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 q = regRdata;
    @(posedge core_clk);
  endtask
  task automatic fop(input fsp_pkg::fsp_op_t op, input logic [18:0] a, input logic [7:0] d, input logic [1:0] hv);
    int n;
    n = 0;
    wr(fsp_pkg::REG_ADDR, {13'h0, a});
    wr(fsp_pkg::REG_DATA, {24'h0, d});
    wr(fsp_pkg::REG_CTRL, {26'h0, hv, op, 1'b1});
    st = 32'h1;
    while (st[0] !== 1'b0 && n < 3000) begin
      rd(fsp_pkg::REG_STATUS, st);
      n++;
    end
    if (n >= 3000) chk("op wait", 32'h1, 32'h0);
  endtask
  task automatic fw(input logic [18:0] a, input logic [7:0] d);
    fop(fsp_pkg::OP_WRITE, a, d, 2'b00);
  endtask
  task automatic unl(input logic [7:0] c);
    fw(19'h555, 8'hAA);
    fw(19'h2AA, 8'h55);
    fw(19'h555, c);
  endtask
  task automatic frd(input logic [18:0] a, input logic [1:0] hv, output logic [31:0] q);
    fop(fsp_pkg::OP_READ, a, 8'h00, hv);
    rd(fsp_pkg::REG_RDATA, q);
  endtask
  task automatic poll(input logic [18:0] a);
    fop(fsp_pkg::OP_POLL, a, 8'h00, 2'b00);
  endtask
  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    {core_clk, nrst, regWr, regRd, failMode, regAddr, regWdata} = '0;
    errTotal = 0;
    checked = 0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("idle pins", {27'h0, flashCeN, flashWeN, flashOeN, hvAddrEn, hvOeEn}, 32'h1C);
    frd(19'h00010, 2'b00, v);
    chk("blank", v, 32'hFF);
    fin("reset");
    unl(8'hA0);
    fw(19'h00010, 8'h1C);
    poll(19'h00010);
    chk("prog status", {29'h0, st[3:1]}, 32'h1);
    frd(19'h00010, 2'b00, v);
    chk("prog data", v, 32'h1C);
    unl(8'hA0);
    fw(19'h00010, 8'hC3);
    poll(19'h00010);
    chk("nonblank status", {29'h0, st[3:1]}, 32'h1);
    frd(19'h00010, 2'b00, v);
    chk("nonblank data", v, 32'h00);
    fin("program");
    unl(8'h80);
    fw(19'h555, 8'hAA);
    fw(19'h2AA, 8'h55);
    fw(19'h00010, 8'h30);
    fw(19'h10000, 8'h30);
    frd(19'h10000, 2'b00, w);
    frd(19'h10000, 2'b00, v);
    chk("window open", {30'h0, w[3], v[3]}, 32'h0);
    chk("erase toggles", {29'h0, v[7], v[6] ^ w[6], v[2] ^ w[2]}, 32'h3);
    frd(19'h10000, 2'b00, v);
    chk("window shut", {31'h0, v[3]}, 32'h1);
    poll(19'h10000);
    // Erased byte has bit five high after a toggle, so the host notes it and rechecks
    chk("erase status", {29'h0, st[3:1]}, 32'h5);
    frd(19'h00010, 2'b00, v);
    chk("erased", v, 32'hFF);
    fin("erase");
    failMode <= 1'b1;
    unl(8'hA0);
    fw(19'h00030, 8'h11);
    poll(19'h00030);
    chk("fail status", {29'h0, st[3:1]}, 32'h6);
    failMode <= 1'b0;
    unl(8'hA0);
    fw(19'h00040, 8'h00);
    fop(fsp_pkg::OP_RESET, 19'h00030, 8'h00, 2'b00);
    frd(19'h00030, 2'b00, v);
    chk("after reset", v, 32'h11);
    frd(19'h00040, 2'b00, v);
    chk("ignored prog", v, 32'hFF);
    fin("timeout");
    fop(fsp_pkg::OP_PROTECT, 19'h60000, 8'h00, 2'b11);
    frd(19'h60002, 2'b01, v);
    chk("prot verify", v, 32'h1);
    frd(19'h60000, 2'b01, v);
    chk("id code", v, {24'h0, ID_CODE});
    frd(19'h50002, 2'b01, v);
    chk("unprot sector", v, 32'h0);
    unl(8'hA0);
    fw(19'h60005, 8'h00);
    frd(19'h60005, 2'b00, v);
    chk("prot keep", v, 32'hFF);
    unl(8'h90);
    frd(19'h60002, 2'b00, v);
    chk("id prot", v, 32'h1);
    fop(fsp_pkg::OP_RESET, 19'h00000, 8'h00, 2'b00);
    for (int s = 0; s < 8; s++) fop(fsp_pkg::OP_PROTECT, {s[2:0], 16'h0}, 8'h00, 2'b11);
    fop(fsp_pkg::OP_UNPROT, 19'h60000, 8'h00, 2'b11);
    frd(19'h60002, 2'b01, v);
    chk("chip unprot", v, 32'h0);
    fin("protect");
    results();
  end
  // Watchdog on a hung run
  initial begin
    #(60000 * 5);
    errTotal++;
    results();
  end
endmodule // test_fsp_host
